// *** shared/prs_defs.svh ***
// Purpose: Register map, field positions, reset values and timing counts of the PLD control block
// Assumes: 40 MHz system clock, byte addresses on a 32-bit Wishbone bus
// Notes:   Shared by the design and the bench
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH

// ==========================================================
// Register byte addresses
`define PRS_ADDR_CTRL       8'h00
`define PRS_ADDR_PRELOAD    8'h04
`define PRS_ADDR_SECURE     8'h08
`define PRS_ADDR_VERIFY     8'h0c
`define PRS_ADDR_SIG_LO     8'h10
`define PRS_ADDR_SIG_HI     8'h14
`define PRS_ADDR_STATUS     8'h18

// ==========================================================
// Field positions
`define PRS_CTRL_MODE_LSB   0
`define PRS_CTRL_CFG_LSB    16
`define PRS_PL_VAL_LSB      0
`define PRS_PL_MASK_LSB     8
`define PRS_ST_SECURED      8
`define PRS_ST_RUN          9
`define PRS_ST_REFUSED      10

// ==========================================================
// Reset values and fixed answers
`define PRS_CFG_RESET       16'hffff
`define PRS_VERIFY_BLANK    32'h0000_0000
`define PRS_PIN_O_RESET     8'hff

// ==========================================================
// Timing
`define PRS_CLK_PERIOD_NS   25
`define PRS_TPR_MAX_NS      1000
`define PRS_PR_CYCLES       (`PRS_TPR_MAX_NS / `PRS_CLK_PERIOD_NS)

`endif

// *** shared/prs_pkg.sv ***
// Purpose: Types of the PLD control block
// Assumes: Used with prs_defs.svh
// Notes:   Enum codes follow declaration order from 0
package prs_pkg;

	// ==========================================================
	// Global architecture modes
	typedef enum logic [1:0] {MODE_REG, MODE_CPLX, MODE_SIMPLE} prs_mode_t;

	// ==========================================================
	// Macrocell configurations
	typedef enum logic [1:0] {CELL_REG, CELL_CIO, CELL_COUT, CELL_IN} prs_cell_t;

	// ==========================================================
	// Power-up sequence
	typedef enum logic [1:0] {PU_RESET, PU_WAIT, PU_RUN} prs_pu_t;

endpackage

// *** hdl/prs_top.sv ***
// Purpose: Power-up reset, preload, security lock, signature and macrocell modes of a small PLD
// Assumes: All inputs synchronous to CLK; product-term sums arrive ready-made on SUM_I
// Notes:   The array clock pin is sampled and edge-detected, not used as a clock
//
// Behaviour
// - After power-up all macrocell registers clear low with no array clock edge.
// - Registered outputs drive the inverted register, so they show high after reset.
// - Programmer can preload each macrocell register high or low individually.
// - Secured device refuses configuration verify and register preload.
// - Signature stays readable whether or not the device is secured.
// - Sixty-four bits of user signature, eight bytes, freely writable.
// - Security lock acts at once, so set it last.
// - Each macrocell is registered, combinatorial I/O, combinatorial output or input.
// - One global mode at a time decides how macrocells behave.
// - In registered mode common clock and common enable serve all registered cells.
//
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "prs_defs.svh"

module prs_top #(
	parameter int NCELL     = 8,
	parameter int PR_CYCLES = `PRS_PR_CYCLES
) (
	input  wire logic              CLK,
	input  wire logic              RST,
	input  wire logic              WB_CYC_I,
	input  wire logic              WB_STB_I,
	input  wire logic              WB_WE_I,
	input  wire logic [7:0]        WB_ADR_I,
	input  wire logic [3:0]        WB_SEL_I,
	input  wire logic [31:0]       WB_DAT_I,
	output logic      [31:0]       WB_DAT_O,
	output logic                   WB_ACK_O,
	input  wire logic              ARRAY_CLK_I,
	input  wire logic              OE_N_I,
	input  wire logic [NCELL-1:0]  SUM_I,
	input  wire logic [NCELL-1:0]  OE_TERM_I,
	input  wire logic [NCELL-1:0]  PIN_I,
	input  wire logic [NCELL-1:0]  PIN_DRV_I,
	output logic      [NCELL-1:0]  PIN_O,
	output logic      [NCELL-1:0]  PIN_OE,
	output logic      [NCELL-1:0]  ARRAY_IN,
	output prs_pkg::prs_mode_t     MODE
);
	import prs_pkg::*;

	// ==========================================================
	// Elaboration checks
	if (NCELL < 1 || NCELL > 8) begin : g_bad_ncell
		$error("NCELL must be 1 to 8");
	end
	if (PR_CYCLES < 1 || PR_CYCLES > 63) begin : g_bad_pr
		$error("PR_CYCLES must be 1 to 63");
	end

	// ==========================================================
	// State
	prs_pu_t          pu_q;
	logic [5:0]       pr_cnt_q;
	logic [NCELL-1:0] reg_q;
	logic [15:0]      cfg_q;
	prs_mode_t        mode_q;
	logic             secure_q;
	logic [63:0]      sig_q;
	logic             refused_q;
	logic             clk_pin_q;
	logic             ack_q;

	logic             wb_req;
	logic             wr_en;
	logic             pl_wr;
	logic             run;
	logic             clk_rise;
	logic [NCELL-1:0] reg_cell;
	logic [NCELL-1:0] pl_val;
	logic [NCELL-1:0] pl_mask;
	logic [1:0]       new_mode;

	assign wb_req   = WB_CYC_I & WB_STB_I & ~ack_q;
	// Writes land on the edge where the master sees ack
	assign wr_en    = WB_CYC_I & WB_STB_I & WB_WE_I & ack_q;
	assign pl_wr    = wr_en && WB_ADR_I == `PRS_ADDR_PRELOAD;
	assign run      = pu_q == PU_RUN;
	assign clk_rise = run & ARRAY_CLK_I & ~clk_pin_q;
	assign pl_val   = WB_DAT_I[`PRS_PL_VAL_LSB +: NCELL];
	assign pl_mask  = WB_DAT_I[`PRS_PL_MASK_LSB +: NCELL];
	assign new_mode = WB_DAT_I[`PRS_CTRL_MODE_LSB +: 2];

	// Register cells only exist in registered mode
	always_comb begin
		for (int i = 0; i < NCELL; i++) begin
			reg_cell[i] = mode_q == MODE_REG && prs_cell_t'(cfg_q[2*i +: 2]) == CELL_REG;
		end
	end

	// ==========================================================
	// Power-up sequence
	// Edges on the array clock are ignored until the interval ends
	always_ff @(posedge CLK) begin
		if (RST) begin
			pu_q     <= PU_RESET;
			pr_cnt_q <= 6'h00;
		end else begin
			case (pu_q)
				PU_RESET: begin
					pu_q     <= PU_WAIT;
					pr_cnt_q <= 6'h00;
				end
				PU_WAIT: begin
					pr_cnt_q <= pr_cnt_q + 6'h01;
					if (pr_cnt_q == 6'(PR_CYCLES - 1)) begin
						pu_q <= PU_RUN;
					end
				end
				PU_RUN: pu_q <= PU_RUN;
				default: pu_q <= PU_RESET;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			clk_pin_q <= 1'b1;
		end else begin
			clk_pin_q <= ARRAY_CLK_I;
		end
	end

	// ==========================================================
	// Macrocell registers
	always_ff @(posedge CLK) begin
		if (RST || !run) begin
			reg_q <= '0;
		end else begin
			for (int i = 0; i < NCELL; i++) begin
				if (pl_wr && !secure_q && pl_mask[i]) begin
					reg_q[i] <= pl_val[i];
				end else if (clk_rise && reg_cell[i]) begin
					reg_q[i] <= SUM_I[i];
				end
			end
		end
	end

	// ==========================================================
	// Pins
	always_ff @(posedge CLK) begin
		if (RST) begin
			PIN_O    <= NCELL'(`PRS_PIN_O_RESET);
			PIN_OE   <= '0;
			ARRAY_IN <= '1;
		end else begin
			for (int i = 0; i < NCELL; i++) begin
				ARRAY_IN[i] <= PIN_DRV_I[i] ? PIN_I[i] : 1'b1;
				PIN_O[i]    <= SUM_I[i];
				PIN_OE[i]   <= 1'b1;
				if (reg_cell[i]) begin
					PIN_O[i]  <= ~reg_q[i];
					PIN_OE[i] <= ~OE_N_I;
				end else begin
					case (prs_cell_t'(cfg_q[2*i +: 2]))
						CELL_CIO: PIN_OE[i] <= OE_TERM_I[i];
						CELL_IN:  PIN_OE[i] <= 1'b0;
						default:  PIN_OE[i] <= 1'b1;
					endcase
				end
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			MODE <= MODE_REG;
		end else begin
			MODE <= mode_q;
		end
	end

	// ==========================================================
	// Configuration, security, signature
	// Config stays writable when secured; only the verify readback is hidden, CTRL still reads it back
	always_ff @(posedge CLK) begin
		if (RST) begin
			mode_q <= MODE_REG;
			cfg_q  <= `PRS_CFG_RESET;
		end else if (wr_en && WB_ADR_I == `PRS_ADDR_CTRL) begin
			if (new_mode != 2'h3) begin
				mode_q <= prs_mode_t'(new_mode);
			end
			cfg_q <= WB_DAT_I[`PRS_CTRL_CFG_LSB +: 16];
		end
	end

	// Fuse is one-way; only reset clears it
	always_ff @(posedge CLK) begin
		if (RST) begin
			secure_q <= 1'b0;
		end else if (wr_en && WB_ADR_I == `PRS_ADDR_SECURE && WB_DAT_I[0]) begin
			secure_q <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			sig_q <= '0;
		end else if (wr_en && (WB_ADR_I == `PRS_ADDR_SIG_LO || WB_ADR_I == `PRS_ADDR_SIG_HI)) begin
			for (int b = 0; b < 4; b++) begin
				if (WB_SEL_I[b]) begin
					sig_q[(WB_ADR_I[2] ? 32 : 0) + 8*b +: 8] <= WB_DAT_I[8*b +: 8];
				end
			end
		end
	end

	// Refusal flag tracks the latest verify or preload attempt
	always_ff @(posedge CLK) begin
		if (RST) begin
			refused_q <= 1'b0;
		end else if (pl_wr || (wb_req && !WB_WE_I && WB_ADR_I == `PRS_ADDR_VERIFY)) begin
			refused_q <= secure_q;
		end
	end

	// ==========================================================
	// Wishbone answer: ack one cycle after the request
	always_ff @(posedge CLK) begin
		if (RST) begin
			ack_q    <= 1'b0;
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= '0;
		end else begin
			ack_q    <= wb_req;
			WB_ACK_O <= wb_req;
			if (wb_req && !WB_WE_I) begin
				case (WB_ADR_I)
					`PRS_ADDR_CTRL:   WB_DAT_O <= {cfg_q, 14'h0000, mode_q};
					`PRS_ADDR_VERIFY: WB_DAT_O <= secure_q ? `PRS_VERIFY_BLANK : {cfg_q, 14'h0000, mode_q};
					`PRS_ADDR_SIG_LO: WB_DAT_O <= sig_q[31:0];
					`PRS_ADDR_SIG_HI: WB_DAT_O <= sig_q[63:32];
					`PRS_ADDR_STATUS: WB_DAT_O <= {21'h000000, refused_q, run, secure_q, 8'(reg_q)};
					default:          WB_DAT_O <= 32'h0000_0000;
				endcase
			end else begin
				WB_DAT_O <= 32'h0000_0000;
			end
		end
	end

	// ==========================================================
	// Assertions
	property p_pu_clear;
		@(posedge CLK) RST |=> reg_q == '0;
	endproperty
	a_pu_clear: assert property (p_pu_clear) else $error("registers not cleared by reset");

	// Cycles since reset release, saturating; an independent yardstick for the interval
	logic [6:0] since_rst_q;
	always_ff @(posedge CLK) begin
		if (RST) begin
			since_rst_q <= 7'h00;
		end else if (since_rst_q != 7'h7f) begin
			since_rst_q <= since_rst_q + 7'h01;
		end
	end

	property p_pu_hold;
		@(posedge CLK) disable iff (RST) run |-> since_rst_q > 7'(PR_CYCLES);
	endproperty
	a_pu_hold: assert property (p_pu_hold) else $error("reset interval ended early");

	property p_reg_out;
		@(posedge CLK) disable iff (RST) 1'b1 |=> ((PIN_O ^ ~$past(reg_q)) & $past(reg_cell)) == '0;
	endproperty
	a_reg_out: assert property (p_reg_out) else $error("registered pin not inverse of register");

	property p_preload;
		@(posedge CLK) disable iff (RST)
			pl_wr && !secure_q && run |=> (reg_q & $past(pl_mask)) == ($past(pl_val) & $past(pl_mask));
	endproperty
	a_preload: assert property (p_preload) else $error("preload value not taken");

	property p_pl_block;
		@(posedge CLK) disable iff (RST) pl_wr && secure_q && !clk_rise |=> $stable(reg_q);
	endproperty
	a_pl_block: assert property (p_pl_block) else $error("preload acted while secured");

	property p_verify_blank;
		@(posedge CLK) disable iff (RST)
			wb_req && !WB_WE_I && WB_ADR_I == `PRS_ADDR_VERIFY && secure_q
			|=> WB_ACK_O && WB_DAT_O == `PRS_VERIFY_BLANK && refused_q;
	endproperty
	a_verify_blank: assert property (p_verify_blank) else $error("verify not blanked");

	property p_sig_read;
		@(posedge CLK) disable iff (RST)
			wb_req && !WB_WE_I && WB_ADR_I == `PRS_ADDR_SIG_LO |=> WB_DAT_O == $past(sig_q[31:0]);
	endproperty
	a_sig_read: assert property (p_sig_read) else $error("signature not readable");

	property p_common_oe;
		@(posedge CLK) disable iff (RST) 1'b1 |=> ((PIN_OE ^ {NCELL{~$past(OE_N_I)}}) & $past(reg_cell)) == '0;
	endproperty
	a_common_oe: assert property (p_common_oe) else $error("common enable not followed");

	property p_pullup;
		@(posedge CLK) disable iff (RST) 1'b1 |=> (ARRAY_IN | $past(PIN_DRV_I)) == '1;
	endproperty
	a_pullup: assert property (p_pullup) else $error("undriven pin not seen high");

	property p_secure_sticky;
		@(posedge CLK) disable iff (RST) secure_q |=> secure_q [*4];
	endproperty
	a_secure_sticky: assert property (p_secure_sticky) else $error("security fuse cleared");

	property p_ack_pulse;
		@(posedge CLK) disable iff (RST) wb_req |=> WB_ACK_O ##1 !WB_ACK_O;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single cycle");

endmodule

// *** test/prs_prog_model.sv ***
// Purpose: Array clock source and pin drivers facing the PLD control block
// Assumes: Bench asks for each array clock pulse through fire
// Notes:   Clock stands still between requested pulses
`timescale 1ns/1ps
module prs_prog_model #(
	parameter int HOLD = 8
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       fire,
	input  wire logic [7:0] pin_val,
	input  wire logic [7:0] pin_en,
	output logic            arr_clk,
	output logic            ready,
	output logic [7:0]      pin_lvl,
	output logic [7:0]      pin_drv
);
	int unsigned cnt;

	// ==========================================================
	// Array clock
	// Held low through the reset interval plus setup margin
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt     <= HOLD;
			arr_clk <= 1'b0;
		end else if (cnt != 0) begin
			cnt     <= cnt - 1;
		end else begin
			arr_clk <= fire && !arr_clk;
		end
	end
	assign ready = (cnt == 0) && !arr_clk;

	// ==========================================================
	// Pins: undriven lines float high
	assign pin_lvl = (pin_val & pin_en) | ~pin_en;
	assign pin_drv = pin_en;
endmodule

// *** test/prs_top_tb.sv ***
// Purpose: Self-checking bench for the PLD control block
// Assumes: Power-up interval shortened to 4 cycles
// Notes:   Registers reached over classic Wishbone
`timescale 1ns/1ps
`include "prs_defs.svh"
module prs_top_tb;
	import prs_pkg::*;
	localparam int PR = 4;
	logic        clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, oe_n = 0, fire = 0;
	logic [7:0]  adr = 0, sum = 0, pval = 0, pen = 0, oet = 8'h0e;
	logic [3:0]  sel = 0;
	logic [31:0] dat = 0, q, dat_o;
	logic        ack, arr_clk, rdy;
	logic [7:0]  pin_o, pin_oe, arr_in, pin_lvl, pin_drv;
	prs_mode_t   mode;
	int          err_count = 0, check_count = 0;

	always #12.5 clk = ~clk;

	prs_top #(.PR_CYCLES(PR)) i_prs_top (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
		.WB_ACK_O(ack), .ARRAY_CLK_I(arr_clk), .OE_N_I(oe_n), .SUM_I(sum), .OE_TERM_I(oet),
		.PIN_I(pin_lvl), .PIN_DRV_I(pin_drv), .PIN_O(pin_o), .PIN_OE(pin_oe),
		.ARRAY_IN(arr_in), .MODE(mode));

	prs_prog_model #(.HOLD(PR + 3)) i_prs_prog_model (.clk(clk), .rst(rst), .fire(fire),
		.pin_val(pval), .pin_en(pen), .arr_clk(arr_clk), .ready(rdy), .pin_lvl(pin_lvl),
		.pin_drv(pin_drv));

	// ==========================================================
	// Tasks
	task automatic finish_test;
		if (err_count == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= s; dat <= d;
		// No local limit: only the watchdog ends a wait for ack
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		q = dat_o;
		cyc <= 0; stb <= 0; we <= 0;
		@(posedge clk);
	endtask

	task automatic tick(input logic [7:0] s);
		sum <= s;
		@(posedge clk);
		repeat (40) if (!rdy) @(posedge clk);
		fire <= 1;
		@(posedge clk);
		fire <= 0;
		repeat (3) @(posedge clk);
	endtask

	// ==========================================================
	// Tests
	initial begin
		repeat (6) @(posedge clk);
		check(pin_o, 8'hff);
		rst <= 0;
		bus(1, `PRS_ADDR_PRELOAD, 4'hf, 32'h0000_ffff);
		bus(0, `PRS_ADDR_STATUS, 4'hf, 0);
		check(q[7:0], 8'h00);
		repeat (20) if (!q[9]) bus(0, `PRS_ADDR_STATUS, 4'hf, 0);
		check(q[9], 1'b1);
		for (int m = 0; m < 3; m++) begin
			bus(1, `PRS_ADDR_CTRL, 4'hf, m);
			bus(0, `PRS_ADDR_VERIFY, 4'hf, 0);
			check(q, m);
			check(mode, m);
		end
		sum <= 8'h96;
		repeat (3) @(posedge clk);
		check(pin_o, 8'h96);
		bus(1, `PRS_ADDR_CTRL, 4'hf, 0);
		bus(1, `PRS_ADDR_PRELOAD, 4'hf, 32'h0000_ff5a);
		bus(0, `PRS_ADDR_STATUS, 4'hf, 0);
		check(q[7:0], 8'h5a);
		bus(1, `PRS_ADDR_PRELOAD, 4'hf, 32'h0000_0f00);
		bus(0, `PRS_ADDR_STATUS, 4'hf, 0);
		check(q[7:0], 8'h50);
		check(pin_o, 8'haf);
		check(pin_oe, 8'hff);
		oe_n <= 1;
		repeat (3) @(posedge clk);
		check(pin_oe, 8'h00);
		oe_n <= 0;
		tick(8'h3c);
		bus(0, `PRS_ADDR_STATUS, 4'hf, 0);
		check(q[7:0], 8'h3c);
		check(pin_o, 8'hc3);
		bus(1, `PRS_ADDR_CTRL, 4'hf, 32'h0003_0000);
		repeat (3) @(posedge clk);
		check(pin_oe, 8'hfe);
		bus(1, `PRS_ADDR_CTRL, 4'hf, 32'h0039_0001);
		repeat (3) @(posedge clk);
		check(pin_oe, 8'hfa);
		check(pin_o, 8'h3c);
		oet <= 8'h0f;
		repeat (3) @(posedge clk);
		check(pin_oe, 8'hfb);
		bus(1, `PRS_ADDR_CTRL, 4'hf, 32'hffff_0000);
		pen <= 8'hf0;
		repeat (3) @(posedge clk);
		check(arr_in, 8'h0f);
		bus(1, `PRS_ADDR_SIG_LO, 4'hf, 32'h1234_5678);
		bus(1, `PRS_ADDR_SIG_HI, 4'hf, 32'h9abc_def0);
		bus(1, `PRS_ADDR_SIG_LO, 4'h2, 32'hffff_ffff);
		bus(0, `PRS_ADDR_SIG_LO, 4'hf, 0);
		check(q, 32'h1234_ff78);
		bus(1, `PRS_ADDR_SECURE, 4'hf, 1);
		bus(0, `PRS_ADDR_VERIFY, 4'hf, 0);
		check(q, 32'h0);
		bus(1, `PRS_ADDR_PRELOAD, 4'hf, 32'h0000_ff00);
		bus(0, `PRS_ADDR_STATUS, 4'hf, 0);
		check(q[10:0], 11'h73c);
		bus(0, `PRS_ADDR_SIG_HI, 4'hf, 0);
		check(q, 32'h9abc_def0);
		bus(0, 8'h1c, 4'hf, 0);
		check(q, 32'h0);
		finish_test;
	end

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		finish_test;
	end
endmodule
